// ==== hw/trc_pkg.sv ====
// constants and types for the thermometer/clock command block
package trc_pkg;
   //----------------------------------------
   // command codes
   //----------------------------------------
   localparam logic [7:0] CMD_CFG = 8'hAC;
   localparam logic [7:0] CMD_START = 8'hEE;
   localparam logic [7:0] CMD_STOP = 8'h22;
   localparam logic [7:0] CMD_TEMP = 8'hAA;
   localparam logic [7:0] CMD_CNT = 8'hA8;
   localparam logic [7:0] CMD_SLOPE = 8'hA9;
   localparam logic [7:0] CMD_CLK = 8'hC0;
   localparam logic [7:0] CMD_CALM = 8'hC7;
   localparam logic [7:0] CMD_HI = 8'hA1;
   localparam logic [7:0] CMD_LO = 8'hA2;
   localparam logic [7:0] CMD_MEM = 8'h17;
   //----------------------------------------
   // config fields and reset values
   //----------------------------------------
   localparam int CFG_ONE_SHOT = 0;
   localparam int CFG_POL = 1;
   localparam int CFG_STBY = 2;
   localparam int CFG_SRC = 4;
   localparam int CFG_DIV = 6;
   localparam logic [7:0] CFG_WMASK = 8'hF7;
   localparam logic [7:0] CFG_HI_RST = 8'hC0;
   localparam logic [15:0] HI_RST = 16'h7F00;
   localparam logic [15:0] LO_RST = 16'h8000;
   localparam logic [7:0] RD_NONE = 8'hFF;
   localparam logic [2:0] DEV_SUB_ADDR = 3'h7;
   localparam logic [2:0] BIT_LAST = 3'h7;
   //----------------------------------------
   // types
   //----------------------------------------
   typedef enum logic [1:0] {
      CV_IDLE = 2'b00, CV_SINGLE = 2'b01, CV_CONT = 2'b11, CV_STOP = 2'b10
   } trc_conv_t;
   typedef enum logic [2:0] {
      EG_IDLE = 3'b000, EG_ADDR = 3'b001, EG_AACK = 3'b011,
      EG_RECV = 3'b010, EG_WACK = 3'b110, EG_SEND = 3'b111,
      EG_MACK = 3'b101
   } trc_eng_t;
   typedef struct packed {
      logic start;
      logic rw;
      logic wr_vld;
      logic [7:0] wr_dat;
      logic rd_go;
      logic stop;
   } trc_ev_t;
   typedef struct packed {
      logic [15:0] result;
      logic [7:0] remain;
      logic [7:0] slope;
   } trc_temp_t;
   typedef struct packed {
      logic we;
      logic sel;
      logic [7:0] addr;
      logic [7:0] wdata;
   } trc_ext_t;
endpackage

// ==== hw/trc_twi_target.sv ====
// two-wire byte engine: start/stop, address match, ack, shifting
`timescale 1ns/1ps
module trc_twi_target #(
   parameter logic [3:0] ADDR_HI = 4'h9 // arbitrary type code
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic [7:0] tx_byte,
   output trc_pkg::trc_ev_t ev
);
   logic scl_q_ff, sda_q_ff, done_ff, rw_ff, oe_ff;
   logic [7:0] sh_ff;
   logic [2:0] cnt_ff;
   trc_pkg::trc_eng_t st_ff;
   trc_pkg::trc_ev_t ev_ff;
   logic rise, fall, st_cond, sp_cond, hit, load;

   assign rise = scl & ~scl_q_ff;
   assign fall = ~scl & scl_q_ff;
   assign st_cond = scl & scl_q_ff & sda_q_ff & ~sda_i;
   assign sp_cond = scl & scl_q_ff & ~sda_q_ff & sda_i;
   assign hit = sh_ff[7:1] == {ADDR_HI, trc_pkg::DEV_SUB_ADDR};
   assign load = fall & ((st_ff == trc_pkg::EG_AACK & rw_ff) |
                         (st_ff == trc_pkg::EG_MACK & done_ff));
   assign sda_o = 1'b0;
   assign sda_oe = oe_ff;
   assign ev = ev_ff;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         scl_q_ff <= scl;
         sda_q_ff <= sda_i;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_ff <= trc_pkg::EG_IDLE;
         sh_ff <= 8'h00;
         cnt_ff <= 3'h0;
         done_ff <= 1'b0;
         rw_ff <= 1'b0;
         oe_ff <= 1'b0;
         ev_ff <= '0;
      end else begin
         ev_ff <= '0;
         if (st_cond) begin
            st_ff <= trc_pkg::EG_ADDR;
            cnt_ff <= 3'h0;
            done_ff <= 1'b0;
            oe_ff <= 1'b0;
         end else if (sp_cond) begin
            st_ff <= trc_pkg::EG_IDLE;
            oe_ff <= 1'b0;
            ev_ff.stop <= 1'b1;
         end else if (load) begin
            // first bit out, rest shifted on later falls
            sh_ff <= {tx_byte[6:0], 1'b0};
            oe_ff <= ~tx_byte[7];
            cnt_ff <= 3'h1;
            st_ff <= trc_pkg::EG_SEND;
         end else begin
            case (st_ff)
               trc_pkg::EG_ADDR, trc_pkg::EG_RECV: begin
                  if (rise) begin
                     sh_ff <= {sh_ff[6:0], sda_i};
                     cnt_ff <= cnt_ff + 3'h1;
                     done_ff <= cnt_ff == trc_pkg::BIT_LAST;
                  end else if (fall && done_ff) begin
                     done_ff <= 1'b0;
                     if (st_ff == trc_pkg::EG_RECV) begin
                        oe_ff <= 1'b1;
                        st_ff <= trc_pkg::EG_WACK;
                        ev_ff.wr_vld <= 1'b1;
                        ev_ff.wr_dat <= sh_ff;
                     end else if (hit) begin
                        oe_ff <= 1'b1;
                        st_ff <= trc_pkg::EG_AACK;
                        rw_ff <= sh_ff[0];
                        ev_ff.start <= 1'b1;
                        ev_ff.rw <= sh_ff[0];
                        ev_ff.rd_go <= sh_ff[0];
                     end else begin
                        st_ff <= trc_pkg::EG_IDLE;
                     end
                  end
               end
               trc_pkg::EG_AACK, trc_pkg::EG_WACK: begin
                  if (fall) begin
                     oe_ff <= 1'b0;
                     cnt_ff <= 3'h0;
                     st_ff <= trc_pkg::EG_RECV;
                  end
               end
               trc_pkg::EG_SEND: begin
                  if (fall) begin
                     if (cnt_ff == 3'h0) begin
                        oe_ff <= 1'b0;
                        done_ff <= 1'b0;
                        st_ff <= trc_pkg::EG_MACK;
                     end else begin
                        oe_ff <= ~sh_ff[7];
                        sh_ff <= {sh_ff[6:0], 1'b0};
                        cnt_ff <= cnt_ff + 3'h1;
                     end
                  end
               end
               trc_pkg::EG_MACK: begin
                  if (rise) begin
                     done_ff <= ~sda_i;
                     ev_ff.rd_go <= ~sda_i;
                  end else if (fall) begin
                     st_ff <= trc_pkg::EG_IDLE;
                  end
               end
               default: st_ff <= trc_pkg::EG_IDLE;
            endcase
         end
      end
   end
endmodule // trc_twi_target

// ==== hw/trc_cmd_cfg.sv ====
// command decoder, configuration/status register and alarm logic
`timescale 1ns/1ps
module trc_cmd_cfg #(
   parameter logic [3:0] ADDR_HI = 4'h9, // arbitrary type code
   parameter int MEM_AW = 5
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire trc_pkg::trc_temp_t temp,
   input wire logic conv_done,
   output logic conv_run,
   input wire logic clock_match,
   output trc_pkg::trc_ext_t ext,
   input wire logic [7:0] ext_rdata,
   input wire logic xtal,
   output logic osc_out,
   output logic alert_pin
);
   //----------------------------------------
   // byte engine
   //----------------------------------------
   trc_pkg::trc_ev_t ev;
   logic [7:0] tx_ff;

   trc_twi_target #(.ADDR_HI(ADDR_HI)) u_twi (
      .clk(clk),
      .nrst(nrst),
      .scl(scl),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe(sda_oe),
      .tx_byte(tx_ff),
      .ev(ev)
   );

   //----------------------------------------
   // command tracking
   //----------------------------------------
   logic [7:0] cmd_ff;
   logic cmd_ok_ff, expect_ff, load_ff;
   logic step_ff;
   logic [1:0] idx_ff;
   logic cmd_byte, dat_byte, rd_adv, addressed, is_clk, known;
   trc_pkg::trc_ext_t ext_ff;
   logic [7:0] nxt_ptr;

   always_comb begin
      case (ev.wr_dat)
         trc_pkg::CMD_CFG, trc_pkg::CMD_START, trc_pkg::CMD_STOP,
         trc_pkg::CMD_TEMP, trc_pkg::CMD_CNT, trc_pkg::CMD_SLOPE,
         trc_pkg::CMD_CLK, trc_pkg::CMD_CALM, trc_pkg::CMD_HI,
         trc_pkg::CMD_LO, trc_pkg::CMD_MEM: known = 1'b1;
         default: known = 1'b0;
      endcase
   end

   assign cmd_byte = ev.wr_vld & expect_ff;
   assign dat_byte = ev.wr_vld & ~expect_ff & cmd_ok_ff;
   assign rd_adv = ev.rd_go & ~ev.start;
   assign is_clk = cmd_ff == trc_pkg::CMD_CLK | cmd_ff == trc_pkg::CMD_CALM;
   assign addressed = is_clk | cmd_ff == trc_pkg::CMD_MEM;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cmd_ff <= 8'h00;
         cmd_ok_ff <= 1'b0;
         expect_ff <= 1'b0;
         idx_ff <= 2'h0;
         load_ff <= 1'b0;
      end else begin
         load_ff <= ev.rd_go;
         if (ev.start) begin
            expect_ff <= ~ev.rw;
            idx_ff <= 2'h0;
         end else if (cmd_byte) begin
            cmd_ff <= ev.wr_dat;
            cmd_ok_ff <= known;
            expect_ff <= 1'b0;
            idx_ff <= 2'h0;
         end else if ((dat_byte | rd_adv) && idx_ff != 2'h3) begin
            idx_ff <= idx_ff + 2'h1;
         end
      end
   end

   // starting byte address first, then auto-increment
   always_comb begin
      nxt_ptr = ext_ff.addr;
      if (dat_byte && addressed && idx_ff == 2'h0) begin
         nxt_ptr = ev.wr_dat;
      end else if (step_ff || (rd_adv && addressed)) begin
         nxt_ptr = ext_ff.addr + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ext_ff <= '0;
         step_ff <= 1'b0;
      end else begin
         // step the pointer only after the write has used it
         step_ff <= dat_byte & addressed & idx_ff != 2'h0;
         ext_ff.addr <= nxt_ptr;
         ext_ff.we <= dat_byte & is_clk & idx_ff != 2'h0;
         ext_ff.sel <= cmd_ff == trc_pkg::CMD_CALM;
         ext_ff.wdata <= ev.wr_dat;
      end
   end
   assign ext = ext_ff;

   //----------------------------------------
   // configuration and limits
   //----------------------------------------
   logic [7:0] cfg_hi_ff, lim_msb_ff;
   logic [15:0] hi_ff, lo_ff;
   logic clk_flag_ff, thr_flag_ff, clk_latch_ff, thr_latch_ff;
   logic [7:0] status_lo;

   assign status_lo = {clk_flag_ff, thr_flag_ff, clk_latch_ff,
                       thr_latch_ff, 4'h0};

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cfg_hi_ff <= trc_pkg::CFG_HI_RST;
      end else if (dat_byte && cmd_ff == trc_pkg::CMD_CFG &&
                   idx_ff == 2'h0) begin
         cfg_hi_ff <= ev.wr_dat & trc_pkg::CFG_WMASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         lim_msb_ff <= 8'h00;
         hi_ff <= trc_pkg::HI_RST;
         lo_ff <= trc_pkg::LO_RST;
      end else if (dat_byte && idx_ff == 2'h0) begin
         lim_msb_ff <= ev.wr_dat;
      end else if (dat_byte && idx_ff == 2'h1) begin
         if (cmd_ff == trc_pkg::CMD_HI) begin
            hi_ff <= {lim_msb_ff, ev.wr_dat};
         end
         if (cmd_ff == trc_pkg::CMD_LO) begin
            lo_ff <= {lim_msb_ff, ev.wr_dat};
         end
      end
   end

   //----------------------------------------
   // user memory
   //----------------------------------------
   logic [7:0] mem [2**MEM_AW];

   always_ff @(posedge clk) begin
      if (dat_byte && cmd_ff == trc_pkg::CMD_MEM && idx_ff != 2'h0) begin
         mem[ext_ff.addr[MEM_AW-1:0]] <= ev.wr_dat;
      end
   end

   //----------------------------------------
   // read data
   //----------------------------------------
   logic [7:0] rd_sel;

   always_comb begin
      case (cmd_ff)
         trc_pkg::CMD_CFG:
            rd_sel = idx_ff == 2'h0 ? cfg_hi_ff :
                     idx_ff == 2'h1 ? status_lo : trc_pkg::RD_NONE;
         trc_pkg::CMD_TEMP:
            rd_sel = idx_ff == 2'h0 ? temp.result[15:8] :
                     idx_ff == 2'h1 ? temp.result[7:0] : trc_pkg::RD_NONE;
         trc_pkg::CMD_HI:
            rd_sel = idx_ff == 2'h0 ? hi_ff[15:8] :
                     idx_ff == 2'h1 ? hi_ff[7:0] : trc_pkg::RD_NONE;
         trc_pkg::CMD_LO:
            rd_sel = idx_ff == 2'h0 ? lo_ff[15:8] :
                     idx_ff == 2'h1 ? lo_ff[7:0] : trc_pkg::RD_NONE;
         trc_pkg::CMD_CNT: rd_sel = temp.remain;
         trc_pkg::CMD_SLOPE: rd_sel = temp.slope;
         trc_pkg::CMD_MEM: rd_sel = mem[ext_ff.addr[MEM_AW-1:0]];
         trc_pkg::CMD_CLK, trc_pkg::CMD_CALM: rd_sel = ext_rdata;
         default: rd_sel = trc_pkg::RD_NONE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         tx_ff <= trc_pkg::RD_NONE;
      end else if (load_ff) begin
         tx_ff <= cmd_ok_ff ? rd_sel : trc_pkg::RD_NONE;
      end
   end

   //----------------------------------------
   // conversion control
   //----------------------------------------
   trc_pkg::trc_conv_t cv_ff, nxt_cv;
   logic boot_ff, conv_run_ff, go, halt, single;

   assign single = cfg_hi_ff[trc_pkg::CFG_ONE_SHOT];
   assign go = (cmd_byte & ev.wr_dat == trc_pkg::CMD_START) |
               (boot_ff & ~cfg_hi_ff[trc_pkg::CFG_STBY]);
   assign halt = cmd_byte & ev.wr_dat == trc_pkg::CMD_STOP;

   always_comb begin
      nxt_cv = cv_ff;
      case (cv_ff)
         trc_pkg::CV_IDLE: begin
            if (go) begin
               nxt_cv = single ? trc_pkg::CV_SINGLE : trc_pkg::CV_CONT;
            end
         end
         trc_pkg::CV_SINGLE: begin
            if (conv_done) begin
               nxt_cv = trc_pkg::CV_IDLE;
            end else if (halt) begin
               nxt_cv = trc_pkg::CV_STOP;
            end
         end
         trc_pkg::CV_CONT: begin
            if (halt) begin
               nxt_cv = trc_pkg::CV_STOP;
            end
         end
         trc_pkg::CV_STOP: begin
            if (conv_done) begin
               nxt_cv = trc_pkg::CV_IDLE;
            end else if (go) begin
               nxt_cv = single ? trc_pkg::CV_SINGLE : trc_pkg::CV_CONT;
            end
         end
         default: nxt_cv = trc_pkg::CV_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cv_ff <= trc_pkg::CV_IDLE;
         conv_run_ff <= 1'b0;
         boot_ff <= 1'b1;
      end else begin
         cv_ff <= nxt_cv;
         conv_run_ff <= nxt_cv != trc_pkg::CV_IDLE;
         boot_ff <= 1'b0;
      end
   end
   assign conv_run = conv_run_ff;

   //----------------------------------------
   // alarm flags and latches
   //----------------------------------------
   logic hot, cold, clk_touch;

   assign hot = $signed(temp.result) > $signed(hi_ff);
   assign cold = $signed(temp.result) < $signed(lo_ff);
   assign clk_touch = is_clk & cmd_ok_ff & (dat_byte | load_ff);

   // independent of alarm_source_select; set wins over clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         clk_flag_ff <= 1'b0;
         clk_latch_ff <= 1'b0;
      end else begin
         if (clock_match) begin
            clk_flag_ff <= 1'b1;
         end else if (clk_touch) begin
            clk_flag_ff <= 1'b0;
         end
         if (clock_match) begin
            clk_latch_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         thr_flag_ff <= 1'b0;
         thr_latch_ff <= 1'b0;
      end else if (conv_done) begin
         if (hot) begin
            thr_flag_ff <= 1'b1;
            thr_latch_ff <= 1'b1;
         end else if (cold) begin
            thr_flag_ff <= 1'b0;
         end
      end
   end

   //----------------------------------------
   // alert pin and oscillator output
   //----------------------------------------
   logic [1:0] src, div;
   logic act, alert_ff, xtal_q_ff, osc_ff;
   logic [2:0] xcnt_ff;

   assign src = cfg_hi_ff[trc_pkg::CFG_SRC +: 2];
   assign div = cfg_hi_ff[trc_pkg::CFG_DIV +: 2];
   assign act = (src[0] & thr_flag_ff) | (src[1] & clk_flag_ff);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         alert_ff <= 1'b1;
      end else begin
         alert_ff <= cfg_hi_ff[trc_pkg::CFG_POL] ? act : ~act;
      end
   end
   assign alert_pin = alert_ff;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         xtal_q_ff <= 1'b0;
         xcnt_ff <= 3'h0;
         osc_ff <= 1'b0;
      end else begin
         xtal_q_ff <= xtal;
         if (xtal & ~xtal_q_ff) begin
            xcnt_ff <= xcnt_ff + 3'h1;
         end
         case (div)
            2'b00: osc_ff <= 1'b0;
            2'b01: osc_ff <= xcnt_ff[2];
            2'b10: osc_ff <= xcnt_ff[1];
            default: osc_ff <= xtal_q_ff;
         endcase
      end
   end
   assign osc_out = osc_ff;

   //----------------------------------------
   // assertions
   //----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_start_cmd;
      cv_ff == trc_pkg::CV_IDLE && cmd_byte &&
      ev.wr_dat == trc_pkg::CMD_START;
   endsequence
   sequence s_single_run;
      cv_ff == trc_pkg::CV_SINGLE && conv_run_ff;
   endsequence

   a_cfg_bit_zero: assert property (cfg_hi_ff[3] == 1'b0)
      else $error("config bit 3 not zero");
   a_alert_level: assert property (##1 alert_pin ==
      ($past(cfg_hi_ff[trc_pkg::CFG_POL]) ? $past(act) : !$past(act)))
      else $error("alert pin polarity wrong");
   a_clock_flag_set: assert property (clock_match |=> clk_flag_ff)
      else $error("clock flag not set");
   a_clock_latch_keep: assert property (clk_latch_ff |=> clk_latch_ff)
      else $error("clock latch dropped");
   a_thermal_latch_keep: assert property (thr_latch_ff |=> thr_latch_ff)
      else $error("thermal latch dropped");
   a_thermal_release: assert property (conv_done && cold && !hot
      |=> !thr_flag_ff)
      else $error("thermal flag not released");
   a_single_start: assert property (s_start_cmd and single
      |=> s_single_run)
      else $error("single conversion not started");
   a_stop_finish: assert property (cv_ff == trc_pkg::CV_CONT && halt
      |=> cv_ff == trc_pkg::CV_STOP && conv_run_ff)
      else $error("stop did not finish conversion");
   a_unknown_cmd: assert property (ev.wr_vld && !expect_ff && !cmd_ok_ff
      |=> $stable(cfg_hi_ff) && $stable(hi_ff) && $stable(lo_ff))
      else $error("unknown command changed state");
   a_osc_off: assert property (div == 2'b00 |=> !osc_out)
      else $error("oscillator output not disabled");
endmodule // trc_cmd_cfg

// ==== sim/trc_master.sv ====
// two-wire bus master model for the command block
`timescale 1ns/1ps
module trc_master (
   input wire logic clk,
   input wire logic sda_oe,
   output logic scl,
   output wire logic sda
);
   logic low_ff = 1'b0;
   // open drain, pull-up when nobody pulls
   assign sda = ~(low_ff | sda_oe);
   initial scl = 1'b1;
   // each clock phase lasts 5 clk
   task automatic half();
      repeat (5) @(negedge clk);
   endtask
   task automatic bitx(input logic b, output logic r);
      low_ff = ~b;
      half();
      scl = 1'b1;
      half();
      r = sda;
      scl = 1'b0;
   endtask
   task automatic start();
      low_ff = 1'b0;
      half();
      scl = 1'b1;
      half();
      low_ff = 1'b1;
      half();
      scl = 1'b0;
   endtask
   task automatic stop();
      low_ff = 1'b1;
      half();
      scl = 1'b1;
      half();
      low_ff = 1'b0;
      half();
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 0; i < 8; i++) begin
         bitx(1'b1, r);
         d = {d[6:0], r};
      end
      bitx(last, r);
   endtask
endmodule // trc_master

// ==== sim/trc_cmd_cfg_tb_top.sv ====
// self-checking bench for the command/config block
`timescale 1ns/1ps
module trc_cmd_cfg_tb_top;
   localparam logic [6:0] ADR = {4'h9, trc_pkg::DEV_SUB_ADDR};
   logic clk = 1'b0, nrst = 1'b0, conv_done = 1'b0, clock_match = 1'b0;
   logic xtal = 1'b0, sda_o, sda_oe, conv_run, osc_out, alert_pin, scl;
   wire sda;
   trc_pkg::trc_temp_t temp = '0;
   trc_pkg::trc_ext_t ext;
   logic [7:0] ext_rdata = 8'h5A;
   logic [16:0] ext_got;
   logic [7:0] lim[2] = '{trc_pkg::CMD_HI, trc_pkg::CMD_LO};
   logic [15:0] tq[$] = '{16'h1E00, 16'h1400, 16'h0500};
   int num_errors = 0, comparisons = 0, cyc = 0, cfg_m, st_m = 0;
   trc_cmd_cfg i_dut (.clk(clk), .nrst(nrst), .scl(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .temp(temp), .conv_done(conv_done),
      .conv_run(conv_run), .clock_match(clock_match), .ext(ext),
      .ext_rdata(ext_rdata), .xtal(xtal), .osc_out(osc_out),
      .alert_pin(alert_pin));
   trc_master i_master (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   initial forever #10 clk = ~clk;
   always @(negedge clk) xtal <= ~xtal;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (ext.we === 1'b1) ext_got <= {ext.sel, ext.addr, ext.wdata};
      if (cyc == 40000) begin
         num_errors++;
         give_verdict();
      end
   end
   //----------------------------------------
   // helpers
   //----------------------------------------
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [16:0] g, input logic [16:0] e);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask
   task automatic cmd(input logic [7:0] c);
      logic a;
      i_master.start();
      i_master.wbyte({ADR, 1'b0}, a);
      chk(a, 1);
      i_master.wbyte(c, a);
   endtask
   task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
      logic a;
      cmd(c);
      for (int i = n - 1; i >= 0; i--) i_master.wbyte(d[i*8 +: 8], a);
      i_master.stop();
   endtask
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      logic a;
      cmd(c);
      i_master.start();
      i_master.wbyte({ADR, 1'b1}, a);
      i_master.rbyte(1'b0, d[15:8]);
      i_master.rbyte(1'b1, d[7:0]);
      i_master.stop();
   endtask
   task automatic done(input logic [15:0] t);
      temp.result = t;
      @(negedge clk) conv_done = 1'b1;
      @(negedge clk) conv_done = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   //----------------------------------------
   // main sequence
   //----------------------------------------
   initial begin
      logic [15:0] d, v;
      logic a, p;
      int cnt, e;
      v = 16'($urandom(32'hB16E));
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      chk(conv_run, 1);
      chk(alert_pin, 1);
      chk(sda_o, 0);
      rd(trc_pkg::CMD_CFG, d);
      chk(d, 16'hC000);
      i_master.start();
      i_master.wbyte({ADR ^ 7'h01, 1'b0}, a);
      chk(a, 0);
      i_master.stop();
      repeat (4) begin
         v = 16'($urandom);
         wr(trc_pkg::CMD_CFG, 1, v);
         cfg_m = v[7:0] & 8'hF7;
         rd(trc_pkg::CMD_CFG, d);
         chk(d, {cfg_m[7:0], 8'h00});
         chk(alert_pin, !cfg_m[1]);
      end
      wr(8'h55, 2, v);
      rd(trc_pkg::CMD_CFG, d);
      chk(d[15:8], cfg_m[7:0]);
      for (int n = 0; n < 4; n++) begin
         wr(trc_pkg::CMD_CFG, 1, 16'(n << 6));
         e = (n == 3) ? 32 : 4 * n;
         cnt = 0;
         p = osc_out;
         repeat (64) begin
            @(negedge clk);
            if (osc_out && !p) cnt++;
            p = osc_out;
         end
         chk(e == 0 ? cnt == 0 : (cnt >= e - 1 && cnt <= e + 1), 1);
      end
      foreach (lim[k]) begin
         v = 16'($urandom);
         wr(lim[k], 2, v);
         rd(lim[k], d);
         chk(d, v);
      end
      v = 16'($urandom);
      wr(trc_pkg::CMD_MEM, 2, v);
      wr(trc_pkg::CMD_MEM, 2, {v[15:8] + 8'h01, ~v[7:0]});
      wr(trc_pkg::CMD_MEM, 1, {8'h00, v[15:8]});
      rd(trc_pkg::CMD_MEM, d);
      chk(d, {v[7:0], ~v[7:0]});
      wr(trc_pkg::CMD_HI, 2, 16'h1900);
      wr(trc_pkg::CMD_LO, 2, 16'h0A00);
      wr(trc_pkg::CMD_CFG, 1, 16'h00D2);
      temp.remain = 8'($urandom);
      temp.slope = 8'($urandom);
      foreach (tq[k]) begin
         done(tq[k]);
         if (tq[k] > 16'h1900) st_m |= 8'h50;
         if (tq[k] < 16'h0A00) st_m &= 8'hBF;
         rd(trc_pkg::CMD_CFG, d);
         chk(d, {8'hD2, st_m[7:0]});
         chk(alert_pin, st_m[6]);
      end
      rd(trc_pkg::CMD_TEMP, d);
      chk(d, temp.result);
      rd(trc_pkg::CMD_CNT, d);
      chk(d, {temp.remain, temp.remain});
      rd(trc_pkg::CMD_SLOPE, d);
      chk(d, {temp.slope, temp.slope});
      wr(trc_pkg::CMD_CFG, 1, 16'h00C0);
      st_m |= 8'h20;
      for (int k = 0; k < 2; k++) begin
         @(negedge clk) clock_match = 1'b1;
         @(negedge clk) clock_match = 1'b0;
         rd(trc_pkg::CMD_CFG, d);
         chk(d[7:0], st_m[7:0] | 8'h80);
         chk(alert_pin, 1);
         v = 16'($urandom);
         wr(k ? trc_pkg::CMD_CALM : trc_pkg::CMD_CLK, 2, v);
         chk(ext_got, {k[0], v});
         rd(trc_pkg::CMD_CFG, d);
         chk(d[7:0], st_m[7:0]);
      end
      ext_rdata = 8'($urandom);
      wr(trc_pkg::CMD_CLK, 1, v);
      @(negedge clk) clock_match = 1'b1;
      @(negedge clk) clock_match = 1'b0;
      rd(trc_pkg::CMD_CLK, d);
      chk(d, {ext_rdata, ext_rdata});
      rd(trc_pkg::CMD_CFG, d);
      chk(d[7:0], st_m[7:0]);
      wr(trc_pkg::CMD_CFG, 1, 16'h00C1);
      wr(trc_pkg::CMD_STOP, 0, v);
      chk(conv_run, 1);
      done(16'h0500);
      chk(conv_run, 0);
      wr(trc_pkg::CMD_START, 0, v);
      chk(conv_run, 1);
      done(16'h0500);
      chk(conv_run, 0);
      wr(trc_pkg::CMD_CFG, 1, 16'h00C0);
      wr(trc_pkg::CMD_START, 0, v);
      done(16'h0500);
      chk(conv_run, 1);
      give_verdict();
   end
endmodule // trc_cmd_cfg_tb_top
